// ===== hw/spl_pkg.sv
/*
  Shared constants for the link-side port toward the external physical layer.
  Assumes a 125 MHz system clock; the physical layer clock arrives on a pin.
*/
package spl_pkg;
  // phase codes on the two-bit phase bus
  localparam logic [1:0] SPL_CTL_IDLE = 2'h0;
  localparam logic [1:0] SPL_CTL_STATUS = 2'h1;
  localparam logic [1:0] SPL_CTL_RECEIVE = 2'h2;
  localparam logic [1:0] SPL_CTL_GRANT = 2'h3;
  // link-driven codes
  localparam logic [1:0] SPL_LCTL_HOLD = 2'h2;
  localparam logic [1:0] SPL_LCTL_XMIT = 2'h1;
  localparam logic [1:0] SPL_LCTL_IDLE = 2'h0;
  // link clock divider: half period in system clocks
  localparam int SPL_CLK_HZ = 125000000;
  localparam int SPL_LINK_CLK_HZ = 50000000;
  localparam int SPL_LINK_CLK_HALF = (SPL_CLK_HZ / SPL_LINK_CLK_HZ) / 2 < 1 ? 1
                                     : (SPL_CLK_HZ / SPL_LINK_CLK_HZ) / 2;
  localparam logic [7:0] SPL_DATA_RST = 8'h00;
  localparam logic [1:0] SPL_CTL_RST = 2'h0;
  typedef enum logic [1:0] {
    SPL_S_PHY = 2'b00,
    SPL_S_REQ = 2'b01,
    SPL_S_XMIT = 2'b11,
    SPL_S_END = 2'b10
  } spl_state_t;
endpackage

// ===== hw/spl_link_port.sv
/*
  Link-side pin logic toward the physical layer: clock out, phase bus,
  data bus, request line and one general io pin.
  Assumes the physical layer clock and all pins are asynchronous to i_ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module spl_link_port
  import spl_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // system
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // user side
  input wire logic i_tx_req,
  input wire logic [DATA_W-1:0] i_tx_data,
  input wire logic i_tx_last,
  input wire logic i_io_dir,
  input wire logic i_io_out,
  output logic o_tx_taken,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_valid,
  output logic [1:0] o_phase,
  output logic o_io_in,
  // physical layer pins
  input wire logic i_phy_clk,
  input wire logic [1:0] i_ctl,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_gpio,
  output logic o_link_side_clock_out,
  output logic o_link_service_request,
  output logic [1:0] o_ctl,
  output logic o_ctl_oen,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oen,
  output logic o_gpio,
  output logic o_gpio_oen
);
  // byte lanes and the 8-bit divider counter are fixed in size
  if (DATA_W != 8) begin : g_bad_width
    $error("data width must be 8");
  end
  if (SPL_LINK_CLK_HALF < 1 || SPL_LINK_CLK_HALF > 256) begin : g_bad_half
    $error("link clock half period out of range");
  end

  logic [1:0] pclk_sync;
  logic [1:0] ctl_s1, ctl_s2;
  logic [DATA_W-1:0] dat_s1, dat_s2;
  logic [1:0] gpio_sync;
  logic pclk_prev;
  logic pclk_rise;
  logic [7:0] div_cnt;
  logic link_clk_wrap;
  logic link_clk_rise;
  spl_state_t state;

  // two flops on every pin before use
  always_ff @(posedge i_ref_clk) begin
    pclk_sync <= {pclk_sync[0], i_phy_clk};
    ctl_s1 <= i_ctl;
    ctl_s2 <= ctl_s1;
    dat_s1 <= i_data;
    dat_s2 <= dat_s1;
    gpio_sync <= {gpio_sync[0], i_gpio};
    pclk_prev <= pclk_sync[1];
  end

  // sample buses on phy clock rising edge
  assign pclk_rise = pclk_sync[1] & ~pclk_prev;

  // link clock derived by divider
  assign link_clk_wrap = (div_cnt == 8'(SPL_LINK_CLK_HALF - 1));
  // edge at which the link clock goes high; link-driven phase codes launch here
  assign link_clk_rise = link_clk_wrap & ~o_link_side_clock_out;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      div_cnt <= 8'h00;
      o_link_side_clock_out <= 1'b0;
    end else if (link_clk_wrap) begin
      div_cnt <= 8'h00;
      o_link_side_clock_out <= ~o_link_side_clock_out;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // ownership state machine
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= SPL_S_PHY;
    end else if (pclk_rise) begin
      case (state)
        SPL_S_PHY: begin
          if (i_tx_req) state <= SPL_S_REQ;
        end
        SPL_S_REQ: begin
          if (ctl_s2 == SPL_CTL_GRANT) state <= SPL_S_XMIT;
        end
        SPL_S_XMIT: begin
          if (i_tx_last) state <= SPL_S_END;
        end
        default: state <= SPL_S_PHY;
      endcase
    end
  end

  // request line held while waiting for grant
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) o_link_service_request <= 1'b0;
    else o_link_service_request <= (state == SPL_S_REQ);
  end

  // phase code follows the link clock, not the phy clock;
  // it may settle before the enable drops, which is harmless while released
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_ctl <= SPL_CTL_RST;
    end else if (link_clk_rise) begin
      case (state)
        SPL_S_XMIT: o_ctl <= SPL_LCTL_XMIT;
        SPL_S_END: o_ctl <= SPL_LCTL_IDLE;
        default: o_ctl <= o_ctl;
      endcase
    end
  end

  // bus drivers; link takes the bus on a phy edge seen in XMIT and releases it on one seen in PHY/REQ
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_ctl_oen <= 1'b1;
      o_data_oen <= 1'b1;
      o_data <= SPL_DATA_RST;
      o_tx_taken <= 1'b0;
    end else begin
      o_tx_taken <= 1'b0;
      if (pclk_rise) begin
        case (state)
          SPL_S_XMIT: begin
            o_ctl_oen <= 1'b0;
            o_data_oen <= 1'b0;
            o_data <= i_tx_data;
            o_tx_taken <= 1'b1;
          end
          SPL_S_END: begin
            o_data <= SPL_DATA_RST;
          end
          default: begin
            o_ctl_oen <= 1'b1;
            o_data_oen <= 1'b1;
          end
        endcase
      end
    end
  end

  // receive side when phy owns the bus
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rx_data <= SPL_DATA_RST;
      o_rx_valid <= 1'b0;
      o_phase <= SPL_CTL_RST;
    end else begin
      o_rx_valid <= pclk_rise && o_ctl_oen && ctl_s2 == SPL_CTL_RECEIVE;
      if (pclk_rise) begin
        o_rx_data <= dat_s2;
        o_phase <= o_ctl_oen ? ctl_s2 : o_ctl;
      end
    end
  end

  // general io pin zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_gpio_oen <= 1'b1;
      o_gpio <= 1'b0;
      o_io_in <= 1'b0;
    end else begin
      o_gpio_oen <= ~i_io_dir;
      o_gpio <= i_io_out;
      o_io_in <= gpio_sync[1];
    end
  end

  chk_reset_release: assert property (@(posedge i_ref_clk)
    !i_rstn |=> o_ctl_oen && o_data_oen)
    else $error("link drives bus after reset");
  chk_drive_owner: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $fell(o_data_oen) |-> $past(state) == SPL_S_XMIT)
    else $error("bus driven without grant");
  sequence s_req_wait;
    state == SPL_S_REQ ##1 state == SPL_S_REQ;
  endsequence
  chk_req_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_req_wait |-> o_link_service_request)
    else $error("request not raised");
  chk_io_dir: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##1 o_gpio_oen == !$past(i_io_dir))
    else $error("io direction wrong");
  chk_ctl_oen_pair: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_ctl_oen == o_data_oen)
    else $error("bus enables split");
  chk_data_edge: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $changed(o_data) |-> $past(pclk_rise))
    else $error("data changed off phy edge");
  chk_ctl_edge: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $changed(o_ctl) |-> $past(link_clk_rise))
    else $error("phase changed off link clock edge");
  chk_link_clk_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_rstn |=> $changed(o_link_side_clock_out) == $past(link_clk_wrap))
    else $error("link clock toggled at wrong time");
  chk_taken_xmit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_tx_taken |-> !o_data_oen)
    else $error("data taken while released");
endmodule
`default_nettype wire

// ===== tb/spl_phy_model.sv
/*
  Behavioural physical layer: free clock, phase and data drive.
  Assumes the link releases a bus by raising its oen.
*/
`timescale 1ns/1ns
`default_nettype none
module spl_phy_model (
  // link pins
  input wire logic [1:0] i_lctl,
  input wire logic i_lctl_oen,
  input wire logic [7:0] i_ldata,
  input wire logic i_ldata_oen,
  input wire logic i_lgpio,
  input wire logic i_lgpio_oen,
  // bench control
  input wire logic [1:0] i_pctl,
  input wire logic [7:0] i_pdata,
  // resolved wires
  output logic o_pclk,
  output logic [1:0] o_ctl,
  output logic [7:0] o_data,
  output logic o_gpio
);
  initial begin
    o_pclk = 1'b0;
    forever #80 o_pclk = ~o_pclk;
  end
  // phy takes the bus back whenever the link lets go
  assign o_ctl = i_lctl_oen ? i_pctl : i_lctl;
  assign o_data = i_ldata_oen ? i_pdata : i_ldata;
  // pull-up holds an undriven pin
  assign o_gpio = i_lgpio_oen ? 1'b1 : i_lgpio;
endmodule
`default_nettype wire

// ===== tb/tb_serial_bus_phy_link_port.sv
/*
  Self-checking bench: reset state, transmit, receive, io pin zero.
  Assumes the behavioural phy model beside the port.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_serial_bus_phy_link_port;
  import spl_pkg::*;
  logic i_ref_clk, i_rstn, i_tx_req, i_tx_last, i_io_dir, i_io_out, l;
  logic o_tx_taken, o_rx_valid, o_io_in, o_link_side_clock_out, o_link_service_request;
  logic o_ctl_oen;
  logic o_data_oen, o_gpio, o_gpio_oen;
  logic [7:0] i_tx_data, o_rx_data, o_data, pdata;
  logic [1:0] o_phase, o_ctl, pctl;
  wire logic i_phy_clk, i_gpio;
  wire logic [1:0] i_ctl;
  wire logic [7:0] i_data;
  int failures = 0, compares = 0, cyc = 0, n;
  spl_link_port dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_tx_req(i_tx_req),
    .i_tx_data(i_tx_data), .i_tx_last(i_tx_last), .i_io_dir(i_io_dir), .i_io_out(i_io_out),
    .o_tx_taken(o_tx_taken), .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
    .o_phase(o_phase), .o_io_in(o_io_in), .i_phy_clk(i_phy_clk), .i_ctl(i_ctl),
    .i_data(i_data), .i_gpio(i_gpio), .o_link_side_clock_out(o_link_side_clock_out),
    .o_link_service_request(o_link_service_request), .o_ctl(o_ctl), .o_ctl_oen(o_ctl_oen),
    .o_data(o_data), .o_data_oen(o_data_oen), .o_gpio(o_gpio), .o_gpio_oen(o_gpio_oen));
  spl_phy_model phy_u (.i_lctl(o_ctl), .i_lctl_oen(o_ctl_oen), .i_ldata(o_data),
    .i_ldata_oen(o_data_oen), .i_lgpio(o_gpio), .i_lgpio_oen(o_gpio_oen),
    .i_pctl(pctl), .i_pdata(pdata), .o_pclk(i_phy_clk), .o_ctl(i_ctl),
    .o_data(i_data), .o_gpio(i_gpio));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  // sample 1 ns after the edge so registered outputs have landed
  task automatic step(int k);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic t_reset;
    `CHK("ctl_oen", 1'b1, o_ctl_oen)
    `CHK("data_oen", 1'b1, o_data_oen)
    `CHK("service_request", 1'b0, o_link_service_request)
    l = o_link_side_clock_out;
    step(1);
    `CHK("link_clock", ~l, o_link_side_clock_out)
  endtask
  task automatic t_tx;
    @(posedge i_ref_clk);
    i_tx_data <= 8'hA5;
    i_tx_last <= 1'b1;
    i_tx_req <= 1'b1;
    for (n = 0; n < 100 && o_link_service_request !== 1'b1; n++) step(1);
    `CHK("service_request", 1'b1, o_link_service_request)
    `CHK("oen pre", 1'b1, o_data_oen)
    @(posedge i_ref_clk);
    pctl <= SPL_CTL_GRANT;
    for (n = 0; n < 100 && o_tx_taken !== 1'b1; n++) step(1);
    `CHK("data", 8'hA5, o_data)
    `CHK("data_oen", 1'b0, o_data_oen)
    `CHK("ctl", SPL_LCTL_XMIT, o_ctl)
    @(posedge i_ref_clk);
    i_tx_req <= 1'b0;
    pctl <= SPL_CTL_IDLE;
    for (n = 0; n < 200 && o_ctl_oen !== 1'b1; n++) step(1);
    `CHK("ctl_oen end", 1'b1, o_ctl_oen)
    `CHK("data_oen end", 1'b1, o_data_oen)
  endtask
  task automatic t_rx;
    @(posedge i_ref_clk);
    pdata <= 8'h3C;
    pctl <= SPL_CTL_RECEIVE;
    for (n = 0; n < 100 && o_rx_valid !== 1'b1; n++) step(1);
    `CHK("rx_data", 8'h3C, o_rx_data)
    `CHK("phase", SPL_CTL_RECEIVE, o_phase)
    `CHK("ctl_oen rx", 1'b1, o_ctl_oen)
    @(posedge i_ref_clk);
    pctl <= SPL_CTL_IDLE;
  endtask
  task automatic t_io;
    @(posedge i_ref_clk);
    i_io_dir <= 1'b1;
    step(6);
    `CHK("gpio_oen out", 1'b0, o_gpio_oen)
    `CHK("io_in out", 1'b0, o_io_in)
    `CHK("gpio out", 1'b0, o_gpio)
    @(posedge i_ref_clk);
    i_io_dir <= 1'b0;
    step(6);
    `CHK("gpio_oen in", 1'b1, o_gpio_oen)
    `CHK("io_in pull", 1'b1, o_io_in)
  endtask
  initial begin
    i_rstn = 1'b0;
    {i_tx_req, i_tx_last, i_io_dir, i_io_out} = 4'h0;
    i_tx_data = 8'h00;
    pdata = 8'h00;
    pctl = SPL_CTL_IDLE;
    repeat (12) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    step(2);
    t_reset();
    t_tx();
    t_rx();
    t_io();
    tally_and_finish();
  end
endmodule
`default_nettype wire
